// [core/ict_pkg.sv]
/*
 * Constants, register map and carrier types of the IR counter/timer pair.
 * Assumes an 8-bit register port with one-cycle strobes.
 */
`default_nettype none
package ict_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] NARROW_CTRL_OFS = 8'h00;
	localparam logic [7:0] SHARED_CTRL_OFS = 8'h01;
	localparam logic [7:0] WIDE_CTRL_OFS   = 8'h02;
	localparam logic [7:0] PAIR_CTRL_OFS   = 8'h03;
	localparam logic [7:0] NARROW_RLD_OFS  = 8'h04;
	localparam logic [7:0] WIDE_RLD_LO_OFS = 8'h06;
	localparam logic [7:0] WIDE_RLD_HI_OFS = 8'h07;
	localparam logic [7:0] WIDE_CAP_LO_OFS = 8'h08;
	localparam logic [7:0] WIDE_CAP_HI_OFS = 8'h09;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int PAIR_WIDE_EN   = 7;
	localparam int PAIR_NARROW_EN = 6;
	localparam int PAIR_SYNC      = 5;
	localparam int CTL_EN         = 7;
	localparam int CTL_TIMEOUT    = 5;
	localparam int WIDE_SINGLE    = 6;
	localparam int WIDE_CAP_MASK  = 2;
	localparam int WIDE_CNT_MASK  = 1;
	localparam int WIDE_DEMOD     = 0;
	localparam int SHR_ALT_RUN    = 7;
	localparam int SHR_EDGE_HI    = 5;
	localparam int SHR_EDGE_LO    = 4;
	localparam int SHR_RISE_FLAG  = 1;
	localparam int SHR_FALL_FLAG  = 0;
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [7:0]  RELOAD_RESET = 8'hff;
	localparam logic [15:0] WIDE_FULL    = 16'hffff;
	localparam logic [15:0] WIDE_TERM    = 16'h0001;
	localparam logic [7:0]  NARROW_TERM  = 8'h01;
	localparam int          TICK_NS      = 80;
	localparam int          CLK_NS       = 10;
	localparam int          TICK_CYCLES  = (TICK_NS + CLK_NS - 1) / CLK_NS;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		DM_IDLE  = 2'b00,
		DM_WAIT  = 2'b01,
		DM_COUNT = 2'b11
	} ict_demod_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ict_bus_req_t;
endpackage : ict_pkg
`default_nettype wire

// [core/ict_tick.sv]
/*
 * Count-rate divider: one-cycle tick every DIV clocks.
 * Assumes restart is a one-cycle pulse in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ict_tick #(
	parameter int DIV = ict_pkg::TICK_CYCLES
) (
	input  wire logic CLK,
	input  wire logic RESET,
	input  wire logic restart,
	output var  logic tick
);
	logic [15:0] cnt_q;

	// Restart realigns the phase so both counters see the same first tick
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cnt_q <= 16'h0000;
			tick  <= 1'b0;
		end else if (restart || cnt_q == 16'(DIV - 1)) begin
			cnt_q <= 16'h0000;
			tick  <= !restart;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick  <= 1'b0;
		end
	end
endmodule : ict_tick
`default_nettype wire

// [core/ict_timer_pair.sv]
/*
 * Paired 8-bit / 16-bit counter/timer with demodulation capture and
 * alternating run. Assumes synchronous EDGE_IN and a one-cycle-strobe
 * register port; read data appear in the cycle after the read strobe.
 */
// Function
// RL1 - Pair register bit 7 starts/stops the wide counter, bit 6 the narrow one, reads show running state, bit 5 is sync mode, all reset 0.
// RL2 - Software avoids rewriting hold registers at the instant they are loaded into the counter.
// RL3 - Software never programs an initial wide count of one.
// RL4 - From an initial count of zero the wide counter wraps to FFFFH and keeps counting.
// RL5 - The zero to FFFFH wrap is neither a timeout nor terminal count.
// RL6 - Software writes FFH to both wide reload bytes before demodulation.
// RL7 - In demodulation the wide counter waits for the first selected edge, then captures, reloads and counts.
// RL8 - With single-edge clear, every later edge captures the complemented count.
// RL9 - Each capture sets its edge status flag and interrupts if the capture mask allows.
// RL10 - After each capture the wide counter reloads FFFFH and counts on.
// RL11 - With single-edge set only the first edge captures.
// RL12 - In alternating run hardware swaps the two enable bits at each timeout.
// RL13 - In alternating run each timeout sets that counter's timeout flag.
// RL14 - The wide timeout flag is set at terminal count and cleared by writing one.
// RL15 - Timeout and capture interrupts are each gated by their own mask bit.
// RL16 - The edge input is synchronised and edge-detected before use.
`timescale 1ns/1ps
`default_nettype none
module ict_timer_pair #(
	parameter int DIV = ict_pkg::TICK_CYCLES
) (
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output var  logic [7:0] RDATA,
	input  wire logic       EDGE_IN,
	output var  logic       WIDE_OUT,
	output var  logic       NARROW_OUT,
	output var  logic       IRQ_TIMEOUT,
	output var  logic       IRQ_CAPTURE
);
	ict_pkg::ict_bus_req_t req;
	ict_pkg::ict_demod_t   dm_q;
	logic [7:0]  nctl_q, shr_q, wctl_q, nrld_q, wrl_q, wrh_q, caph_q, capl_q;
	logic        wen_q, nen_q, sync_q, wrun_q, nrun_q;
	logic [15:0] wcnt_q;
	logic [7:0]  ncnt_q;
	logic        e1_q, e2_q, e3_q, tick, rise, fall, qual, cap_ev;
	logic        w_to, n_to, w_cnt_ok, alt, demod;

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	function automatic logic wr_at(input ict_pkg::ict_bus_req_t r,
		input logic [7:0] a);
		return r.wr && r.addr == a;
	endfunction : wr_at

	ict_tick #(.DIV(DIV)) u_tick (
		.CLK    (CLK),
		.RESET  (RESET),
		.restart(sync_q && wr_at(req, ict_pkg::PAIR_CTRL_OFS)),
		.tick   (tick)
	);

	// ****************************************
	// Edge input
	// ****************************************
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			e1_q <= 1'b0;
			e2_q <= 1'b0;
			e3_q <= 1'b0;
		end else begin
			e1_q <= EDGE_IN; // [RL16]
			e2_q <= e1_q;
			e3_q <= e2_q;
		end
	end
	assign rise  = e2_q && !e3_q; // [RL16]
	assign fall  = !e2_q && e3_q;
	assign qual  = (shr_q[ict_pkg::SHR_EDGE_LO] && rise) ||
		(shr_q[ict_pkg::SHR_EDGE_HI] && fall);
	assign demod = wctl_q[ict_pkg::WIDE_DEMOD];
	assign alt   = shr_q[ict_pkg::SHR_ALT_RUN];
	// Single-edge mode ignores every edge after the first capture
	assign cap_ev = demod && wen_q && wrun_q && qual && (dm_q == ict_pkg::DM_WAIT
		|| (dm_q == ict_pkg::DM_COUNT && !wctl_q[ict_pkg::WIDE_SINGLE])); // [RL7] [RL11]
	assign w_cnt_ok = wen_q && wrun_q && !cap_ev && (!demod || dm_q == ict_pkg::DM_COUNT);
	// Only a count of one is terminal; the zero case wraps silently
	assign w_to = w_cnt_ok && tick && wcnt_q == ict_pkg::WIDE_TERM; // [RL5]
	assign n_to = nen_q && nrun_q && tick && ncnt_q == ict_pkg::NARROW_TERM;

	// ****************************************
	// Enables
	// ****************************************
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wen_q  <= 1'b0;
			nen_q  <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			if (wr_at(req, ict_pkg::PAIR_CTRL_OFS)) begin
				wen_q  <= req.wdata[ict_pkg::PAIR_WIDE_EN]; // [RL1]
				nen_q  <= req.wdata[ict_pkg::PAIR_NARROW_EN];
				sync_q <= req.wdata[ict_pkg::PAIR_SYNC];
			end else begin
				if (wr_at(req, ict_pkg::WIDE_CTRL_OFS))
					wen_q <= req.wdata[ict_pkg::CTL_EN];
				else if (alt && (w_to || n_to))
					wen_q <= n_to; // [RL12]
				if (wr_at(req, ict_pkg::NARROW_CTRL_OFS))
					nen_q <= req.wdata[ict_pkg::CTL_EN];
				else if (alt && (w_to || n_to))
					nen_q <= w_to; // [RL12]
			end
		end
	end

	// ****************************************
	// Control and hold registers
	// ****************************************
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			nctl_q <= ict_pkg::CTRL_RESET;
			shr_q  <= ict_pkg::CTRL_RESET;
			wctl_q <= ict_pkg::CTRL_RESET;
			nrld_q <= ict_pkg::RELOAD_RESET;
			wrl_q  <= ict_pkg::RELOAD_RESET;
			wrh_q  <= ict_pkg::RELOAD_RESET;
		end else begin
			if (wr_at(req, ict_pkg::SHARED_CTRL_OFS))
				shr_q[7:2] <= req.wdata[7:2];
			if (wr_at(req, ict_pkg::WIDE_CTRL_OFS)) begin
				wctl_q[7:6] <= req.wdata[7:6];
				wctl_q[4:0] <= req.wdata[4:0];
			end
			if (wr_at(req, ict_pkg::NARROW_CTRL_OFS)) begin
				nctl_q[7:6] <= req.wdata[7:6];
				nctl_q[4:0] <= req.wdata[4:0];
			end
			// Set wins over a same-cycle write of one
			if (w_to) // [RL13] [RL14]
				wctl_q[ict_pkg::CTL_TIMEOUT] <= 1'b1;
			else if (wr_at(req, ict_pkg::WIDE_CTRL_OFS) &&
				req.wdata[ict_pkg::CTL_TIMEOUT])
				wctl_q[ict_pkg::CTL_TIMEOUT] <= 1'b0; // [RL14]
			if (n_to) // [RL13]
				nctl_q[ict_pkg::CTL_TIMEOUT] <= 1'b1;
			else if (wr_at(req, ict_pkg::NARROW_CTRL_OFS) &&
				req.wdata[ict_pkg::CTL_TIMEOUT])
				nctl_q[ict_pkg::CTL_TIMEOUT] <= 1'b0;
			for (int i = ict_pkg::SHR_FALL_FLAG; i <= ict_pkg::SHR_RISE_FLAG; i++) begin
				if (cap_ev && (i == ict_pkg::SHR_RISE_FLAG ? rise : fall))
					shr_q[i] <= 1'b1; // [RL9]
				else if (wr_at(req, ict_pkg::SHARED_CTRL_OFS) && req.wdata[i])
					shr_q[i] <= 1'b0;
			end
			if (wr_at(req, ict_pkg::NARROW_RLD_OFS))
				nrld_q <= req.wdata;
			// A reload in the same cycle takes the old hold value
			if (wr_at(req, ict_pkg::WIDE_RLD_LO_OFS)) // [RL2] [RL6]
				wrl_q <= req.wdata;
			if (wr_at(req, ict_pkg::WIDE_RLD_HI_OFS))
				wrh_q <= req.wdata;
		end
	end

	// ****************************************
	// Wide counter and demodulation
	// ****************************************
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wcnt_q <= ict_pkg::WIDE_FULL;
			wrun_q <= 1'b0;
			dm_q   <= ict_pkg::DM_IDLE;
			caph_q <= 8'h00;
			capl_q <= 8'h00;
		end else begin
			wrun_q <= wen_q;
			if (!wen_q) begin
				dm_q <= ict_pkg::DM_IDLE;
			end else if (!wrun_q) begin
				// Initial count of one would time out at once
				wcnt_q <= {wrh_q, wrl_q}; // [RL3]
				dm_q   <= demod ? ict_pkg::DM_WAIT : ict_pkg::DM_IDLE;
			end else if (cap_ev) begin
				{caph_q, capl_q} <= ~wcnt_q; // [RL8]
				wcnt_q <= ict_pkg::WIDE_FULL; // [RL10]
				dm_q   <= ict_pkg::DM_COUNT; // [RL7]
			end else if (w_cnt_ok && tick) begin
				if (w_to)
					wcnt_q <= {wrh_q, wrl_q};
				else
					wcnt_q <= wcnt_q - 16'h0001; // [RL4]
			end
		end
	end

	// ****************************************
	// Narrow counter and outputs
	// ****************************************
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ncnt_q <= ict_pkg::RELOAD_RESET;
			nrun_q <= 1'b0;
		end else begin
			nrun_q <= nen_q;
			if (nen_q && (!nrun_q || n_to))
				ncnt_q <= nrld_q;
			else if (nen_q && tick)
				ncnt_q <= ncnt_q - 8'h01;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			WIDE_OUT    <= 1'b0;
			NARROW_OUT  <= 1'b0;
			IRQ_TIMEOUT <= 1'b0;
			IRQ_CAPTURE <= 1'b0;
		end else begin
			WIDE_OUT    <= WIDE_OUT ^ w_to;
			NARROW_OUT  <= NARROW_OUT ^ n_to;
			IRQ_TIMEOUT <= w_to && wctl_q[ict_pkg::WIDE_CNT_MASK]; // [RL15]
			IRQ_CAPTURE <= cap_ev && wctl_q[ict_pkg::WIDE_CAP_MASK]; // [RL9] [RL15]
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			RDATA <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				ict_pkg::NARROW_CTRL_OFS: RDATA <= {nen_q, nctl_q[6:0]};
				ict_pkg::SHARED_CTRL_OFS: RDATA <= shr_q;
				ict_pkg::WIDE_CTRL_OFS:   RDATA <= {wen_q, wctl_q[6:0]};
				ict_pkg::PAIR_CTRL_OFS:   RDATA <= {wen_q, nen_q, sync_q, 5'h00}; // [RL1]
				ict_pkg::NARROW_RLD_OFS:  RDATA <= nrld_q;
				ict_pkg::WIDE_RLD_LO_OFS: RDATA <= wrl_q;
				ict_pkg::WIDE_RLD_HI_OFS: RDATA <= wrh_q;
				ict_pkg::WIDE_CAP_LO_OFS: RDATA <= capl_q;
				ict_pkg::WIDE_CAP_HI_OFS: RDATA <= caph_q;
				default:                  RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_pair_start: assert property (@(posedge CLK) disable iff (RESET) // [RL1]
		wr_at(req, ict_pkg::PAIR_CTRL_OFS) |=> wen_q == $past(WDATA[7]))
		else $error("pair write did not set wide enable");
	chk_zero_wrap: assert property (@(posedge CLK) disable iff (RESET) // [RL4]
		(w_cnt_ok && tick && wcnt_q == 16'h0000) |=> wcnt_q == 16'hffff)
		else $error("zero count did not wrap to full");
	chk_wrap_quiet: assert property (@(posedge CLK) disable iff (RESET) // [RL5]
		(w_cnt_ok && tick && wcnt_q == 16'h0000) |=>
		!IRQ_TIMEOUT && !$rose(wctl_q[ict_pkg::CTL_TIMEOUT]))
		else $error("wrap raised timeout");
	chk_capture_value: assert property (@(posedge CLK) disable iff (RESET) // [RL8]
		cap_ev |=> {caph_q, capl_q} == ~$past(wcnt_q))
		else $error("capture not complemented count");
	chk_capture_reload: assert property (@(posedge CLK) disable iff (RESET) // [RL10]
		cap_ev |=> wcnt_q == 16'hffff && dm_q == ict_pkg::DM_COUNT)
		else $error("capture did not reload");
	chk_single_edge: assert property (@(posedge CLK) disable iff (RESET) // [RL11]
		(dm_q == ict_pkg::DM_COUNT && wctl_q[6]) |-> !cap_ev)
		else $error("later edge captured in single mode");
	chk_edge_flag: assert property (@(posedge CLK) disable iff (RESET) // [RL9]
		(cap_ev && rise) |=> shr_q[1])
		else $error("rising flag not set");
	chk_alt_swap: assert property (@(posedge CLK) disable iff (RESET) // [RL12]
		(alt && n_to && !w_to && !req.wr) |=> wen_q && !nen_q)
		else $error("alternate run did not swap");
	chk_timeout_flag: assert property (@(posedge CLK) disable iff (RESET) // [RL14]
		w_to |=> wctl_q[5] ##1 (wctl_q[5] || $past(req.wr)))
		else $error("timeout flag lost");
	chk_irq_mask: assert property (@(posedge CLK) disable iff (RESET) // [RL15]
		IRQ_TIMEOUT |-> $past(w_to) && $past(wctl_q[1]))
		else $error("timeout interrupt unmasked");
	chk_edge_sync: assert property (@(posedge CLK) disable iff (RESET) // [RL16]
		$rose(EDGE_IN) ##1 EDGE_IN ##1 EDGE_IN |-> rise)
		else $error("edge not seen two cycles later");
	cov_capture: cover property (@(posedge CLK) disable iff (RESET) cap_ev);
	cov_alt: cover property (@(posedge CLK) disable iff (RESET) alt && w_to);
	cov_wrap: cover property (@(posedge CLK) disable iff (RESET)
		w_cnt_ok && tick && wcnt_q == 16'h0000);
endmodule : ict_timer_pair
`default_nettype wire

// [testbench/ict_timer_pair_tb_top.sv]
/*
 * Self-checking bench of the IR counter/timer pair.
 * Assumes the one-cycle-strobe register port and DIV set to 2.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(NM, EX, GT) begin checks_done++; if ((GT) !== (EX)) begin \
	err_total++; $display("ERROR %s exp %h got %h", NM, EX, GT); end end
module ict_timer_pair_tb_top;
	// ********************
	// Signals and map
	// ********************
	localparam logic [7:0] a_nctl = ict_pkg::NARROW_CTRL_OFS;
	localparam logic [7:0] a_shr  = ict_pkg::SHARED_CTRL_OFS;
	localparam logic [7:0] a_wctl = ict_pkg::WIDE_CTRL_OFS;
	localparam logic [7:0] a_pair = ict_pkg::PAIR_CTRL_OFS;
	localparam logic [7:0] a_nrl  = ict_pkg::NARROW_RLD_OFS;
	localparam logic [7:0] a_wlo  = ict_pkg::WIDE_RLD_LO_OFS;
	localparam logic [7:0] a_whi  = ict_pkg::WIDE_RLD_HI_OFS;
	localparam logic [7:0] a_clo  = ict_pkg::WIDE_CAP_LO_OFS;
	localparam logic [7:0] a_chi  = ict_pkg::WIDE_CAP_HI_OFS;
	localparam logic [7:0] c0     = ict_pkg::CTRL_RESET;
	localparam logic [7:0] r0     = ict_pkg::RELOAD_RESET;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] e;
	} ict_row_t;
	logic       CLK, RESET, WR, RD, EDGE_IN, s;
	logic [7:0] ADDR, WDATA, RDATA, d, h;
	logic       WIDE_OUT, NARROW_OUT, IRQ_TIMEOUT, IRQ_CAPTURE;
	logic [3:0] mon;
	int         err_total = 0;
	int         checks_done = 0;
	int         cyc = 0;
	int         n, m, t1;
	// Unmapped offsets 05 and 0a read as zero
	ict_row_t   rows [0:10] = '{'{a_nctl, c0}, '{a_shr, c0}, '{a_wctl, c0},
		'{a_pair, c0}, '{a_nrl, r0}, '{a_wlo, r0}, '{a_whi, r0},
		'{a_clo, 8'h00}, '{a_chi, 8'h00}, '{8'h05, 8'h00}, '{8'h0a, 8'h00}};
	ict_timer_pair #(.DIV(2)) dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EDGE_IN(EDGE_IN),
		.WIDE_OUT(WIDE_OUT), .NARROW_OUT(NARROW_OUT),
		.IRQ_TIMEOUT(IRQ_TIMEOUT), .IRQ_CAPTURE(IRQ_CAPTURE));
	assign mon = {NARROW_OUT, WIDE_OUT, IRQ_CAPTURE, IRQ_TIMEOUT};
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) cyc <= cyc + 1;
	// ********************
	// Tasks
	// ********************
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CLK);
		ADDR  <= a;
		WDATA <= v;
		WR    <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge CLK);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask : rd
	// Bounded wait; a miss counts as a mismatch
	task automatic wait_bit(input int b, input logic v, input int lim,
			output int k);
		k = 0;
		do begin
			@(posedge CLK);
			#1 k++;
		end while (mon[b] !== v && k < lim);
		if (mon[b] !== v) begin
			err_total++;
			$display("ERROR wait bit %0d exp %b got %b", b, v, mon[b]);
		end
	endtask : wait_bit
	task automatic count_bit(input int b, input int c, output int k);
		k = 0;
		repeat (c) begin
			@(posedge CLK);
			#1 if (mon[b] === 1'b1) k++;
		end
	endtask : count_bit
	task automatic report_and_stop;
		$display("Counts: %0d checks, %0d mismatches", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (10000) @(posedge CLK);
		err_total++;
		report_and_stop();
	end
	// ********************
	// Tests
	// ********************
	initial begin
		RESET = 1'b1;
		WR = 1'b0;
		RD = 1'b0;
		EDGE_IN = 1'b0;
		ADDR = 8'h00;
		WDATA = 8'h00;
		repeat (16) @(posedge CLK);
		`CHK("outputs in reset", 4'h0, mon)
		RESET <= 1'b0;
		wr(a_clo, 8'h55);
		foreach (rows[i]) begin
			rd(rows[i].a, d);
			`CHK("reset value", rows[i].e, d)
		end
		@(posedge CLK);
		#1 `CHK("rdata idle", 8'h00, RDATA)
		wr(a_pair, 8'h20);
		rd(a_pair, d);
		`CHK("sync bit", 8'h20, d)
		$display("test reset and map done");
		wr(a_wlo, 8'h03);
		wr(a_whi, 8'h00);
		wr(a_wctl, 8'h02);
		wr(a_pair, 8'h80);
		rd(a_pair, d);
		`CHK("wide running", 8'h80, d)
		wait_bit(0, 1'b1, 40, n);
		wait_bit(0, 1'b0, 40, n);
		wait_bit(0, 1'b1, 40, m);
		`CHK("timeout period", 6, n + m)
		wr(a_pair, 8'h00);
		rd(a_wctl, d);
		`CHK("timeout flag", 8'h22, d)
		wr(a_wctl, 8'h02);
		rd(a_wctl, d);
		`CHK("flag kept on zero", 8'h22, d)
		wr(a_wctl, 8'h22);
		rd(a_wctl, d);
		`CHK("flag cleared", 8'h02, d)
		wr(a_wctl, 8'h00);
		wr(a_pair, 8'h80);
		count_bit(0, 30, n);
		`CHK("masked irq", 0, n)
		wr(a_pair, 8'h00);
		rd(a_wctl, d);
		`CHK("flag when masked", 8'h20, d)
		wr(a_wctl, 8'h22);
		wr(a_wlo, 8'h00);
		s = WIDE_OUT;
		wr(a_pair, 8'h80);
		count_bit(0, 300, n);
		`CHK("no wrap timeout", 0, n)
		`CHK("no wrap toggle", s, WIDE_OUT)
		wr(a_pair, 8'h00);
		rd(a_wctl, d);
		`CHK("no wrap flag", 8'h02, d)
		$display("test timeout done");
		wr(a_wlo, 8'hff);
		wr(a_whi, 8'hff);
		wr(a_shr, 8'h10);
		wr(a_wctl, 8'h05);
		wr(a_pair, 8'h80);
		count_bit(1, 20, n);
		`CHK("no edge no capture", 0, n)
		@(posedge CLK);
		EDGE_IN <= 1'b1;
		t1 = cyc;
		wait_bit(1, 1'b1, 10, n);
		rd(a_shr, d);
		`CHK("rise flag", 8'h12, d)
		wr(a_shr, 8'h12);
		rd(a_shr, d);
		`CHK("rise flag cleared", 8'h10, d)
		@(posedge CLK);
		EDGE_IN <= 1'b0;
		count_bit(1, 10, n);
		`CHK("falling ignored", 0, n)
		while (cyc < t1 + 60) @(posedge CLK);
		EDGE_IN <= 1'b1;
		wait_bit(1, 1'b1, 10, n);
		rd(a_chi, h);
		rd(a_clo, d);
		`CHK("captured span", 1'b1, {h, d} >= 16'd28 && {h, d} <= 16'd32)
		wr(a_pair, 8'h00);
		EDGE_IN <= 1'b0;
		wr(a_shr, 8'h33);
		wr(a_wctl, 8'h45);
		wr(a_pair, 8'h80);
		@(posedge CLK);
		EDGE_IN <= 1'b1;
		wait_bit(1, 1'b1, 10, n);
		@(posedge CLK);
		EDGE_IN <= 1'b0;
		count_bit(1, 10, n);
		`CHK("single edge", 0, n)
		rd(a_shr, d);
		`CHK("single flag", 8'h32, d)
		wr(a_pair, 8'h00);
		wr(a_shr, 8'h33);
		wr(a_wctl, 8'h05);
		wr(a_pair, 8'h80);
		@(posedge CLK);
		EDGE_IN <= 1'b1;
		wait_bit(1, 1'b1, 10, n);
		@(posedge CLK);
		EDGE_IN <= 1'b0;
		wait_bit(1, 1'b1, 10, n);
		`CHK("fall capture", 1'b1, IRQ_CAPTURE)
		rd(a_shr, d);
		`CHK("both flags", 8'h33, d)
		wr(a_pair, 8'h00);
		$display("test demodulation done");
		wr(a_wctl, 8'h00);
		wr(a_wlo, 8'h08);
		wr(a_whi, 8'h00);
		wr(a_nrl, 8'h08);
		wr(a_shr, 8'h80);
		s = WIDE_OUT;
		wr(a_pair, 8'h80);
		wait_bit(2, ~s, 40, n);
		rd(a_pair, d);
		`CHK("swap to narrow", 8'h40, d)
		s = NARROW_OUT;
		wait_bit(3, ~s, 40, n);
		rd(a_pair, d);
		`CHK("swap to wide", 8'h80, d)
		rd(a_nctl, d);
		`CHK("narrow timeout flag", 8'h20, d & 8'h20)
		rd(a_wctl, d);
		`CHK("wide timeout flag", 8'h20, d & 8'h20)
		wr(a_pair, 8'h00);
		$display("test alternating run done");
		wr(a_pair, 8'h80);
		RESET <= 1'b1;
		repeat (2) @(posedge CLK);
		`CHK("outputs in mid reset", 4'h0, mon)
		RESET <= 1'b0;
		rd(a_pair, d);
		`CHK("pair after mid reset", 8'h00, d)
		rd(a_wctl, d);
		`CHK("wide ctrl after mid reset", 8'h00, d)
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule : ict_timer_pair_tb_top
`default_nettype wire
